// >>> rtl/fsr_ctl.sv
// Command acceptance logic for suspend, resume and deep sleep of a serial flash.
`timescale 1ns/1ps
`default_nettype none

module fsr_ctl #(
    parameter int SLEEP_CYC = fsr_pkg::SLEEP_ENTRY_CYC,
    parameter int WAKE_CYC  = fsr_pkg::WAKE_TIME_CYC
) (
    input  wire logic             REF_CLK,
    input  wire logic             SYS_RST,
    input  wire logic             SCK,
    input  wire logic             CS_N,
    input  wire logic [3:0]       DQ_IN,
    input  wire logic             QUAD_MODE,
    input  wire logic             WRITE_IN_PROGRESS,
    input  wire logic             SUSPEND_DONE,
    input  wire logic             SUSPEND_IS_ERASE,
    output logic                  RESUME_PULSE,
    output logic [7:0]            FUNC_STATUS,
    output logic                  SLEEPING,
    output logic                  CMD_VALID,
    output fsr_pkg::fsr_cmd_t     CMD
);
    import fsr_pkg::*;

    initial begin
        if (SLEEP_CYC < 1 || WAKE_CYC < 1 || SLEEP_CYC > 65535 || WAKE_CYC > 65535) begin
            $error("fsr_ctl: cycle counts out of range");
        end
    end

    // ------------------------------------------------------------------
    // Link domain: opcode shifter on the serial clock
    // ------------------------------------------------------------------
    // The serial clock stands still outside frames, so the shifter is reset by select high
    // and the finished opcode is handed over by a toggle held until the next frame.
    logic [7:0] sh_q;
    logic [3:0] cnt_q;
    logic [7:0] op_q;
    logic       op_tgl_q;
    logic [7:0] sh_d;
    logic [3:0] cnt_d;
    wire        link_quad = QUAD_MODE;

    assign sh_d  = link_quad ? {sh_q[3:0], DQ_IN} : {sh_q[6:0], DQ_IN[0]};
    assign cnt_d = link_quad ? cnt_q + 4'd4 : cnt_q + 4'd1;

    always_ff @(posedge SCK or posedge CS_N) begin
        if (CS_N) begin
            sh_q  <= 8'h00;
            cnt_q <= 4'd0;
        end else begin
            sh_q  <= sh_d;
            cnt_q <= (cnt_q[3]) ? cnt_q : cnt_d;
        end
    end

    // Latch the opcode the moment the eighth bit arrives. The toggle needs a known start,
    // and the serial clock may never run while reset is held, so the system reset clears
    // it asynchronously; reset is released long before the host opens its first frame.
    always_ff @(posedge SCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            op_q     <= 8'h00;
            op_tgl_q <= 1'b0;
        end else if (!CS_N && !cnt_q[3] && cnt_d[3]) begin
            op_q     <= sh_d;
            op_tgl_q <= ~op_tgl_q;
        end
    end

    // ------------------------------------------------------------------
    // Crossing into the system clock
    // ------------------------------------------------------------------
    // Only two things cross: the opcode toggle and select itself. The opcode byte is
    // not synchronised bit by bit; it is read only after the toggle has passed two
    // flip-flops, by which time it has been still for several system cycles and stays
    // still until the next frame opens. Select is synchronised on its own so that the
    // frame end is judged in this domain, where the rest of the decision is made.
    // A host that shortens the select-high time below one system cycle can merge two
    // frames into one edge here; the bench keeps well above that.
    logic [2:0] tgl_s_q;
    logic [1:0] cs_s_q;
    logic       cs_prev_q;
    logic       got_op_q;
    logic [7:0] op_sys_q;

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            tgl_s_q   <= 3'b000;
            cs_s_q    <= 2'b11;
            cs_prev_q <= 1'b1;
        end else begin
            tgl_s_q   <= {tgl_s_q[1:0], op_tgl_q};
            cs_s_q    <= {cs_s_q[0], CS_N};
            cs_prev_q <= cs_s_q[1];
        end
    end

    wire op_arrive = tgl_s_q[2] ^ tgl_s_q[1];
    wire cs_rise   = cs_s_q[1] & ~cs_prev_q;
    wire cs_fall   = ~cs_s_q[1] & cs_prev_q;

    // The toggle lands before select rise is seen, and the opcode is stable until then.
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            got_op_q <= 1'b0;
            op_sys_q <= 8'h00;
        end else if (cs_fall) begin
            got_op_q <= 1'b0;
        end else if (op_arrive) begin
            got_op_q <= 1'b1;
            op_sys_q <= op_q;
        end
    end

    // ------------------------------------------------------------------
    // Acceptance decode
    // ------------------------------------------------------------------
    // Two tables: opcodes that any suspend lets through, and those that only a parked
    // erase lets through. The byte that reads the dynamic bits with a wide address and
    // the one that writes them share a code, so it sits in both tables; in a program
    // suspend it is taken as the read.
    function automatic logic any_susp_ok(input logic [7:0] op);
        case (op)
            8'h03, 8'h13, 8'h0b, 8'h0c, 8'hbb, 8'hbc, 8'h3b, 8'h3c,
            8'heb, 8'hec, 8'h6b, 8'h6c, 8'h0d, 8'h0e, 8'hbd, 8'hbe,
            8'hed, 8'hee: any_susp_ok = 1'b1;
            8'h06, 8'h04, 8'h05, 8'h48, 8'h16, 8'hc8, 8'h61,
            8'h81: any_susp_ok = 1'b1;
            8'hab, 8'h9f, 8'h90, 8'haf, 8'h4b, 8'h5a,
            8'h82: any_susp_ok = 1'b1;
            8'h7a, 8'h30, 8'hc0, 8'h63, 8'h83, 8'h17,
            8'hc5: any_susp_ok = 1'b1;
            8'hb7, 8'h29: any_susp_ok = 1'b1;
            8'hfc, 8'hf2, 8'hfa, 8'he0, 8'he7, 8'ha7,
            8'h2b: any_susp_ok = 1'b1;
            default: any_susp_ok = 1'b0;
        endcase
    endfunction

    function automatic logic erase_susp_ok(input logic [7:0] op);
        case (op)
            8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3e, 8'h75,
            8'hb0: erase_susp_ok = 1'b1;
            8'h24, 8'h26, 8'h25, 8'hfb, 8'he0: erase_susp_ok = 1'b1;
            default: erase_susp_ok = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Suspend flags and power state
    // ------------------------------------------------------------------
    logic       program_suspended_flag_q;
    logic       erase_suspended_flag_q;
    fsr_pwr_t   pwr_q;
    logic [15:0] tmr_q;
    logic       resume_q;
    logic       valid_q;
    fsr_cmd_t   cmd_q;

    wire [7:0] op        = op_sys_q;
    wire       framed    = cs_rise & got_op_q;
    wire       suspended = program_suspended_flag_q | erase_suspended_flag_q;
    wire       is_resume = (op == OP_RESUME_A) || (op == OP_RESUME_B);
    wire       is_sleep  = (op == OP_SLEEP);
    wire       is_wake   = (op == OP_WAKE);
    wire       susp_ok   = any_susp_ok(op) | (erase_suspended_flag_q & erase_susp_ok(op));
    wire       active    = (pwr_q == FSR_ACTIVE);
    wire       sleep_blk = is_sleep & WRITE_IN_PROGRESS;
    wire       accept    = framed & active & (~suspended | susp_ok)
                           & ~sleep_blk;
    wire       do_resume = accept & suspended & is_resume;
    wire       do_sleep  = accept & is_sleep;
    wire       do_wake   = framed & (pwr_q == FSR_SLEEP) & is_wake
                           & ~WRITE_IN_PROGRESS;
    // The wake opcode is reported as taken as well, although no other opcode is taken
    // until the wake time has run out.
    wire       valid_d   = accept | do_wake;

    // Suspend flags: a suspend finishing in the same cycle as a resume wins, so that a
    // parked operation is never left without its flag.

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            program_suspended_flag_q <= 1'b0;
            erase_suspended_flag_q <= 1'b0;
        end else if (SUSPEND_DONE) begin
            program_suspended_flag_q <= ~SUSPEND_IS_ERASE;
            erase_suspended_flag_q <= SUSPEND_IS_ERASE;
        end else if (do_resume) begin
            program_suspended_flag_q <= 1'b0;
            erase_suspended_flag_q <= 1'b0;
        end
    end

    // Power state: one down-counter serves both the entry time and the wake time,
    // because the two never run at once. While entering or waking nothing is taken,
    // not even a second sleep or wake; a host that hurries simply loses the opcode.
    // The counter is sixteen bits, which bounds both times to 65535 system cycles.
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            pwr_q <= FSR_ACTIVE;
            tmr_q <= 16'h0000;
        end else begin
            case (pwr_q)
                FSR_ACTIVE: begin
                    if (do_sleep) begin
                        pwr_q <= FSR_ENTERING;
                        tmr_q <= 16'(SLEEP_CYC - 1);
                    end
                end
                FSR_ENTERING: begin
                    if (tmr_q == 16'h0000) begin
                        pwr_q <= FSR_SLEEP;
                    end else begin
                        tmr_q <= tmr_q - 16'h0001;
                    end
                end
                FSR_SLEEP: begin
                    if (do_wake) begin
                        pwr_q <= FSR_WAKING;
                        tmr_q <= 16'(WAKE_CYC - 1);
                    end
                end
                FSR_WAKING: begin
                    if (tmr_q == 16'h0000) begin
                        pwr_q <= FSR_ACTIVE;
                    end else begin
                        tmr_q <= tmr_q - 16'h0001;
                    end
                end
                default: pwr_q <= FSR_ACTIVE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    // Every output comes from a flip-flop, which costs one cycle of latency on the
    // status and the strobes. The command word is refreshed every cycle, so it is only
    // meaningful while the valid strobe stands.
    logic [7:0] fs_d;
    always_comb begin
        fs_d              = FR_RESET;
        fs_d[FR_PROGRAM_SUSPENDED_FLAG_BIT] = program_suspended_flag_q;
        fs_d[FR_ERASE_SUSPENDED_FLAG_BIT] = erase_suspended_flag_q;
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            resume_q    <= 1'b0;
            valid_q     <= 1'b0;
            cmd_q       <= '0;
            FUNC_STATUS <= FR_RESET;
            SLEEPING    <= 1'b0;
        end else begin
            resume_q    <= do_resume;
            valid_q     <= valid_d;
            cmd_q       <= '{accepted: valid_d, opcode: op};
            FUNC_STATUS <= fs_d;
            SLEEPING    <= (pwr_q == FSR_SLEEP);
        end
    end

    assign RESUME_PULSE = resume_q;
    assign CMD_VALID    = valid_q;
    assign CMD          = cmd_q;

endmodule
`default_nettype wire

// >>> rtl/fsr_pkg.sv
// Package of constants and types for the suspend, resume and sleep command filter.
package fsr_pkg;

    // ------------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_RESUME_A  = 8'h7a;
    localparam logic [7:0] OP_RESUME_B  = 8'h30;
    localparam logic [7:0] OP_SUSPEND_A = 8'h75;
    localparam logic [7:0] OP_SUSPEND_B = 8'hb0;
    localparam logic [7:0] OP_SLEEP     = 8'hb9;
    localparam logic [7:0] OP_WAKE      = 8'hab;

    // ------------------------------------------------------------------
    // Function register bit positions and reset values
    // ------------------------------------------------------------------
    localparam int          FR_PROGRAM_SUSPENDED_FLAG_BIT = 2;
    localparam int          FR_ERASE_SUSPENDED_FLAG_BIT = 3;
    localparam logic [7:0]  FR_RESET    = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ          = 50;
    localparam int SLEEP_ENTRY_NS   = 3000;
    localparam int WAKE_TIME_NS     = 5000;
    localparam int SLEEP_ENTRY_CYC  = (SLEEP_ENTRY_NS * CLK_MHZ) / 1000;
    localparam int WAKE_TIME_CYC    = (WAKE_TIME_NS * CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FSR_ACTIVE   = 2'b00,
        FSR_ENTERING = 2'b01,
        FSR_SLEEP    = 2'b10,
        FSR_WAKING   = 2'b11
    } fsr_pwr_t;

    typedef struct packed {
        logic       accepted;
        logic [7:0] opcode;
    } fsr_cmd_t;

endpackage

// >>> tb/fsr_ctl_bench.sv
// Self-checking bench of the suspend, resume and sleep command filter.
`timescale 1ns/1ps
`default_nettype none
module fsr_ctl_bench;
    import fsr_pkg::*;
    localparam int SLP = 4;
    localparam int WAK = 6;
    localparam int GAP = 4000;
    logic ref_clk = 1'b0, sys_rst = 1'b1, quad_mode = 1'b0, busy = 1'b0;
    logic sus_done = 1'b0, sus_ers = 1'b0, resume_pulse, sleeping, cmd_valid;
    wire logic sck, cs_n;
    wire logic [3:0] dq;
    logic [7:0] func_status, op;
    fsr_cmd_t cmd;
    int bad_count = 0, compares = 0, pf = 0, ef = 0, slp = 0;
    // Opcodes taken in any suspend, and those taken only while an erase is parked.
    logic [7:0] any_q[$] = '{8'h03, 8'h13, 8'h0b, 8'h0c, 8'hbb, 8'hbc, 8'h3b, 8'h3c, 8'heb,
        8'hec, 8'h6b, 8'h6c, 8'h0d, 8'h0e, 8'hbd, 8'hbe, 8'hed, 8'hee, 8'h06, 8'h04, 8'h05,
        8'h48, 8'h16, 8'hc8, 8'h61, 8'h81, 8'hab, 8'h9f, 8'h90, 8'haf, 8'h4b, 8'h5a, 8'h82,
        8'hc0, 8'h63, 8'h83, 8'h17, 8'hc5, 8'hb7, 8'h29, 8'hfc, 8'hf2, 8'hfa, 8'he0, 8'he7,
        8'ha7, 8'h2b};
    logic [7:0] ers_q[$] = '{8'h24, 8'h26, 8'h25, 8'h75, 8'hb0, 8'h02, 8'h12, 8'h32, 8'h38,
        8'h34, 8'h3e, 8'hfb};
    always #10 ref_clk = ~ref_clk;
    fsr_host_model u_host (.sck(sck), .cs_n(cs_n), .dq(dq));
    fsr_ctl #(.SLEEP_CYC(SLP), .WAKE_CYC(WAK)) u_dut (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
        .SCK(sck), .CS_N(cs_n), .DQ_IN(dq), .QUAD_MODE(quad_mode), .WRITE_IN_PROGRESS(busy),
        .SUSPEND_DONE(sus_done), .SUSPEND_IS_ERASE(sus_ers), .RESUME_PULSE(resume_pulse),
        .FUNC_STATUS(func_status), .SLEEPING(sleeping), .CMD_VALID(cmd_valid), .CMD(cmd));
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic frame(input logic [7:0] o, input logic quad, input int nb);
        bit acc, res, gv, gr;
        logic [7:0] gop;
        if (slp) acc = o == OP_WAKE && !busy;
        else if (pf || ef) acc = o inside {any_q, OP_RESUME_A, OP_RESUME_B} || (ef && o inside {ers_q});
        else acc = !(o == OP_SLEEP && busy);
        acc = acc && nb == (quad ? 2 : 8);
        res = acc && (pf || ef) && o inside {OP_RESUME_A, OP_RESUME_B};
        gv = 0;
        gr = 0;
        gop = 8'h00;
        quad_mode = quad;
        u_host.send(o, quad, nb);
        repeat (10) begin
            tick(1);
            if (cmd_valid === 1'b1) gop = cmd.opcode;
            gv |= cmd_valid === 1'b1 && cmd.accepted === 1'b1;
            gr |= resume_pulse === 1'b1;
        end
        chk("cmd_valid", acc, gv);
        chk("opcode", acc ? o : 8'h00, gop);
        chk("resume_pulse", res, gr);
        if (res) begin
            pf = 0;
            ef = 0;
        end
        if (acc && o == OP_SLEEP) begin
            tick(SLP + 2);
            slp = 1;
        end
        if (acc && slp && o == OP_WAKE) begin
            tick(WAK + 2);
            slp = 0;
        end
        chk("sleeping", slp, sleeping);
        chk("func_status", {ef[0], pf[0], 2'b00}, func_status);
    endtask
    task automatic core_suspend(input logic ers);
        sus_ers = ers;
        sus_done = 1'b1;
        tick(1);
        sus_done = 1'b0;
        tick(3);
        if (ers) ef = 1;
        else pf = 1;
        chk("func_status", {ef[0], pf[0], 2'b00}, func_status);
    endtask
    task automatic tally_and_finish();
        $display("compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        op = 8'($urandom(19687));
        tick(4);
        sys_rst = 1'b0;
        tick(1);
        frame(8'h02, 1'b0, 8);
        core_suspend(1'b0);
        foreach (ers_q[i]) frame(ers_q[i], 1'b0, 8);
        foreach (any_q[i]) frame(any_q[i], i[0], i[0] ? 2 : 8);
        repeat (20) begin
            op = 8'($urandom);
            if (op inside {OP_RESUME_A, OP_RESUME_B}) op = OP_SLEEP;
            frame(op, op[0], op[0] ? 2 : 8);
        end
        frame(OP_RESUME_A, 1'b1, 2);
        tick(GAP);
        core_suspend(1'b1);
        foreach (ers_q[i]) frame(ers_q[i], 1'b1, 2);
        frame(OP_RESUME_B, 1'b0, 8);
        frame(OP_SLEEP, 1'b0, 7);
        busy = 1'b1;
        frame(OP_SLEEP, 1'b0, 8);
        busy = 1'b0;
        frame(OP_SLEEP, 1'b1, 2);
        frame(8'h05, 1'b0, 8);
        busy = 1'b1;
        frame(OP_WAKE, 1'b0, 8);
        busy = 1'b0;
        frame(OP_WAKE, 1'b1, 2);
        frame(OP_SLEEP, 1'b0, 8);
        frame(OP_WAKE, 1'b0, 8);
        frame(8'h06, 1'b1, 2);
        tally_and_finish();
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        bad_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire

// >>> tb/fsr_ctl_monitor.sv
// Checker that ties the filter outputs to their causes at the pins.
`timescale 1ns/1ps
`default_nettype none
module fsr_ctl_monitor
    import fsr_pkg::*;
#(
    parameter int SLEEP_CYC = 4,
    parameter int WAKE_CYC  = 6
) (
    input wire logic       REF_CLK,
    input wire logic       SYS_RST,
    input wire logic       SCK,
    input wire logic       CS_N,
    input wire logic [3:0] DQ_IN,
    input wire logic       QUAD_MODE,
    input wire logic       WRITE_IN_PROGRESS,
    input wire logic       SUSPEND_DONE,
    input wire logic       SUSPEND_IS_ERASE,
    input wire logic       RESUME_PULSE,
    input wire logic [7:0] FUNC_STATUS,
    input wire logic       SLEEPING,
    input wire logic       CMD_VALID,
    input wire fsr_cmd_t   CMD
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    property p_after_cs; CMD_VALID |-> CS_N && $past(CS_N, 3); endproperty
    a_after_cs: assert property (p_after_cs) else $error("early command");
    property p_prog_filter; CMD_VALID && FUNC_STATUS[3:2] == 2'b01 |-> !(CMD.opcode inside
        {8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3e, 8'h75, 8'hb0}); endproperty
    a_prog_filter: assert property (p_prog_filter) else $error("program taken");
    property p_lock_filter; CMD_VALID && FUNC_STATUS[3:2] == 2'b01
        |-> !(CMD.opcode inside {8'h24, 8'h26, 8'h25, 8'hfb}); endproperty
    a_lock_filter: assert property (p_lock_filter) else $error("lock taken");
    property p_resume_clear; RESUME_PULSE |-> ##[0:2] FUNC_STATUS[3:2] == 2'b00; endproperty
    a_resume_clear: assert property (p_resume_clear) else $error("flags kept");
    property p_erase_suspended_flag_set; SUSPEND_DONE && SUSPEND_IS_ERASE |-> ##[1:2] FUNC_STATUS[3]; endproperty
    a_erase_suspended_flag_set: assert property (p_erase_suspended_flag_set) else $error("erase flag missing");
    property p_sleep_entry; CMD_VALID && CMD.opcode == OP_SLEEP && !SLEEPING
        |-> ##[1:300] SLEEPING; endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");
    property p_only_wake; CMD_VALID && SLEEPING
        |-> CMD.opcode == OP_WAKE && !WRITE_IN_PROGRESS; endproperty
    a_only_wake: assert property (p_only_wake) else $error("taken asleep");
    property p_wake_exit; CMD_VALID && SLEEPING |-> ##[0:1] !SLEEPING; endproperty
    a_wake_exit: assert property (p_wake_exit) else $error("still asleep");
    c_sleep: cover property ($rose(SLEEPING));
    c_resume: cover property (RESUME_PULSE);
    c_erase_cmd: cover property (CMD_VALID && FUNC_STATUS[3]);
endmodule
bind fsr_ctl fsr_ctl_monitor #(.SLEEP_CYC(SLEEP_CYC), .WAKE_CYC(WAKE_CYC)) u_mon (
    .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .SCK(SCK), .CS_N(CS_N), .DQ_IN(DQ_IN),
    .QUAD_MODE(QUAD_MODE), .WRITE_IN_PROGRESS(WRITE_IN_PROGRESS), .SUSPEND_DONE(SUSPEND_DONE),
    .SUSPEND_IS_ERASE(SUSPEND_IS_ERASE), .RESUME_PULSE(RESUME_PULSE), .FUNC_STATUS(FUNC_STATUS),
    .SLEEPING(SLEEPING), .CMD_VALID(CMD_VALID), .CMD(CMD));
`default_nettype wire

// >>> tb/fsr_host_model.sv
// Host controller model that frames opcodes on select, clock and data.
`timescale 1ns/1ps
`default_nettype none
module fsr_host_model (
    output logic       sck,
    output logic       cs_n,
    output logic [3:0] dq
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        dq = 4'h5;
    end
    // The clock stands still between frames; idle data is inverted so stale bits never match.
    task automatic send(input logic [7:0] op, input logic quad, input int nb);
        cs_n = 1'b0;
        for (int i = 0; i < nb; i++) begin
            dq = quad ? (i == 0 ? op[7:4] : op[3:0]) : {dq[3:1], op[7 - i]};
            #16 sck = 1'b1;
            #32 sck = 1'b0;
            #16;
        end
        #20 cs_n = 1'b1;
        dq = ~dq;
    endtask
endmodule
`default_nettype wire
